// ---- core/irq_wake_pkg.sv ----
// Constants and types shared by the interrupt and wake controller
package irq_wake_pkg;
    localparam int SRC_N        = 8;
    localparam int PORT_N       = 4;
    localparam int PC_W         = 11;
    localparam int SRC_DIV      = 0;
    localparam int SRC_TMR0     = 1;
    localparam int SRC_PORT     = 2;
    localparam int SRC_RSVD     = 3;
    localparam int SRC_EXT      = 4;
    localparam int SRC_RX       = 5;
    localparam int SRC_TX       = 6;
    localparam int SRC_TMR1     = 7;
    localparam logic [7:0] IMPL_MASK  = 8'hF7;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [3:0] NIB_RESET  = 4'h0;
    localparam logic [PC_W-1:0] PC_RESET    = 11'h000;
    localparam logic [PC_W-1:0] VEC_BASE    = 11'h004;
    localparam logic [PC_W-1:0] VEC_STEP    = 11'h004;
    localparam logic [PC_W-1:0] VEC_LAST    = 11'h020;
    // Oscillator warm-up after stop, in microseconds
    localparam int WARMUP_US     = 1000;
    localparam int CLOCK_MHZ     = 10;
    localparam int WARMUP_CYCLES = WARMUP_US * CLOCK_MHZ;

    typedef enum logic [1:0] {
        PM_RUN    = 2'b00,
        PM_HOLD   = 2'b01,
        PM_WARMUP = 2'b11,
        PM_STOP   = 2'b10
    } power_mode_e;

    typedef logic [SRC_N-1:0] src_vec_t;
endpackage : irq_wake_pkg

// ---- core/pin_sync.sv ----
`timescale 1ns/100ps
// Two-stage synchroniser for a bank of asynchronous pins
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_sync_out
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_r       <= INIT;
            pin_sync_out <= INIT;
        end else begin
            meta_r       <= pin_in;
            pin_sync_out <= meta_r;
        end
    end
endmodule : pin_sync

// ---- core/edge_detect.sv ----
`timescale 1ns/100ps
// Per-bit falling and any-change detection on synchronised levels
module edge_detect #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] fall,
    output logic      [WIDTH-1:0] change
);
    logic [WIDTH-1:0] last_r;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            last_r <= INIT;
        end else begin
            last_r <= level;
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            assign fall[i]   = last_r[i] & ~level[i];
            assign change[i] = last_r[i] ^ level[i];
        end
    endgenerate
endmodule : edge_detect

// ---- core/irq_hold_stop_wake_control.sv ----
`timescale 1ns/100ps
// Interrupt, hold release and stop wake controller
// Notes on behaviour
// - Pending plus enable raises interrupt; port source needs port enable
// - Taking an interrupt blocks all others until global enable or mask write
// - Global disable op blocks every source regardless of mask
// - Each source has its own vector inside 004H to 020H
// - Interrupt in hold runs the routine; return op goes back to hold
// - Accepting an interrupt clears only that source's pending bit
// - 8-bit write-only interrupt mask, bit 3 reserved
// - Pulled-up external pin; enabled falling edge ends hold or interrupts
// - Low level on external pin wakes from stop
// - Stop halts all until external low or enabled wake-port falling edge
// - After stop wake, wait warm-up, then continue after stop op
// - 4-bit write-only stop wake enable per wake-port pin
// - Hold op keeps only oscillator and timers; listed sources release it
// - 8-bit write-only hold release mask, same order, bit 3 reserved
// - Read-only cause register, nibbles readable; bits 5..7 are tmr1, rx, tx
// - Hold op is ignored while any cause bit is one
// - Cause bit clears once its pending and hold enable bits are clear
// - Pending bits set by hardware, cleared by clear op or interrupt taken
// - Reset sets program counter to 000H and clears all flags
// - 4-bit write-only port change enable gates each wake-port pin
// - Serial receive done clears input busy, sets pending 5; transmit sets 6
module irq_hold_stop_wake_control
    import irq_wake_pkg::*;
#(
    parameter int WARMUP_COUNT = irq_wake_pkg::WARMUP_CYCLES
) (
    input  wire logic                        clock,
    input  wire logic                        rst,
    input  wire logic                        ext_irq_n,
    input  wire logic [irq_wake_pkg::PORT_N-1:0] wake_port,
    input  wire logic                        div_overflow,
    input  wire logic                        tmr0_underflow,
    input  wire logic                        tmr1_underflow,
    input  wire logic                        serial_rx_done,
    input  wire logic                        serial_tx_done,
    input  wire logic                        serial_rx_start,
    input  wire logic                        ie_write,
    input  wire logic                        he_write,
    input  wire logic                        pe_write,
    input  wire logic                        se_write,
    input  wire logic [7:0]                  wr_data,
    input  wire logic                        global_irq_enable_op,
    input  wire logic                        global_irq_disable_op,
    input  wire logic                        event_clear_op,
    input  wire logic [7:0]                  event_clear_mask,
    input  wire logic                        hold_op,
    input  wire logic                        stop_op,
    input  wire logic                        return_op,
    input  wire logic                        irq_ack,
    output logic                             irq_req,
    output logic [irq_wake_pkg::PC_W-1:0]    irq_vector,
    output logic [7:0]                       event_pending,
    output logic [3:0]                       hold_cause_low_nibble,
    output logic [3:0]                       hold_cause_high_nibble,
    output logic                             serial_in_busy,
    output logic                             cpu_run,
    output logic                             osc_run,
    output logic [1:0]                       power_mode,
    output logic                             in_isr
);
    logic [7:0]        interrupt_enable_mask;
    logic [7:0]        hold_release_enable;
    logic [7:0]        hold_release_cause;
    logic [3:0]        port_change_enable;
    logic [3:0]        stop_wake_enable;
    logic              irq_block_r;
    logic              hold_resume_r;
    power_mode_e       mode_r;
    power_mode_e       mode_nxt;
    logic [31:0]       warm_cnt_r;
    logic              ext_sync;
    logic [3:0]        port_sync;
    logic              ext_fall;
    logic [3:0]        port_fall;
    logic [3:0]        port_change;
    src_vec_t          ev_set;
    src_vec_t          ev_clear;
    src_vec_t          irq_cand;
    src_vec_t          hold_cand;
    src_vec_t          take_onehot;
    logic [2:0]        take_idx;
    logic              take_any;
    logic              stop_wake;

    // Pull-up on the external pin is modelled by a released level of one
    pin_sync #(.WIDTH(1), .INIT(1'b1)) u_sync_ext (
        .clock        (clock),
        .rst          (rst),
        .pin_in       (ext_irq_n),
        .pin_sync_out (ext_sync)
    );

    pin_sync #(.WIDTH(PORT_N), .INIT(4'hF)) u_sync_port (
        .clock        (clock),
        .rst          (rst),
        .pin_in       (wake_port),
        .pin_sync_out (port_sync)
    );

    edge_detect #(.WIDTH(1), .INIT(1'b1)) u_edge_ext (
        .clock  (clock),
        .rst    (rst),
        .level  (ext_sync),
        .fall   (ext_fall),
        .change ()
    );

    edge_detect #(.WIDTH(PORT_N), .INIT(4'hF)) u_edge_port (
        .clock  (clock),
        .rst    (rst),
        .level  (port_sync),
        .fall   (port_fall),
        .change (port_change)
    );

    // Event sources; only peripherals whose clocks run may report
    always_comb begin
        ev_set           = '0;
        ev_set[SRC_DIV]  = div_overflow;
        ev_set[SRC_TMR0] = tmr0_underflow;
        ev_set[SRC_PORT] = |(port_change & port_change_enable);
        ev_set[SRC_EXT]  = ext_fall;
        ev_set[SRC_RX]   = serial_rx_done;
        ev_set[SRC_TX]   = serial_tx_done;
        ev_set[SRC_TMR1] = tmr1_underflow;
        if (mode_r == PM_STOP || mode_r == PM_WARMUP) begin
            ev_set = '0;
        end
    end

    // Fixed priority: lowest index wins, the rest wait
    always_comb begin
        irq_cand    = event_pending & interrupt_enable_mask
                      & IMPL_MASK;
        take_onehot = irq_cand & (~irq_cand + 8'h01);
        take_idx    = 3'h0;
        for (int k = SRC_N - 1; k >= 0; k--) begin
            if (irq_cand[k]) begin
                take_idx = 3'(k);
            end
        end
        take_any = (|irq_cand) && !irq_block_r && irq_ack &&
                   (mode_r == PM_RUN || mode_r == PM_HOLD);
        hold_cand = event_pending & hold_release_enable & IMPL_MASK;
    end

    always_comb begin
        ev_clear = '0;
        if (event_clear_op) begin
            ev_clear = event_clear_mask;
        end
        if (take_any) begin
            ev_clear = ev_clear | take_onehot;
        end
    end

    // Pending flags: a set in the clearing cycle survives
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            event_pending <= MASK_RESET;
        end else begin
            event_pending <= ((event_pending & ~ev_clear) | ev_set)
                             & IMPL_MASK;
        end
    end

    // Write-only masks
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            interrupt_enable_mask <= MASK_RESET;
            hold_release_enable   <= MASK_RESET;
            port_change_enable    <= NIB_RESET;
            stop_wake_enable      <= NIB_RESET;
        end else begin
            if (ie_write) begin
                interrupt_enable_mask <= wr_data & IMPL_MASK;
            end
            if (he_write) begin
                hold_release_enable <= wr_data & IMPL_MASK;
            end
            if (pe_write) begin
                port_change_enable <= wr_data[3:0];
            end
            if (se_write) begin
                stop_wake_enable <= wr_data[3:0];
            end
        end
    end

    // Global block: set by disable op or by taking an interrupt
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_block_r <= 1'b0;
        end else if (take_any || global_irq_disable_op) begin
            irq_block_r <= 1'b1;
        end else if (global_irq_enable_op || ie_write) begin
            irq_block_r <= 1'b0;
        end
    end

    // Cause bits: cause positions 5..7 are tmr1, rx, tx
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hold_release_cause <= MASK_RESET;
        end else begin
            for (int b = 0; b < SRC_N; b++) begin
                int s;
                s = (b == SRC_RX) ? SRC_TMR1 :
                    (b == SRC_TX) ? SRC_RX   :
                    (b == SRC_TMR1) ? SRC_TX : b;
                if (mode_r == PM_HOLD && hold_cand[s]) begin
                    hold_release_cause[b] <= 1'b1;
                end else if (!event_pending[s] &&
                             !hold_release_enable[s]) begin
                    hold_release_cause[b] <= 1'b0;
                end
            end
        end
    end

    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            PM_RUN: begin
                if (stop_op) begin
                    mode_nxt = PM_STOP;
                end else if (hold_op && hold_release_cause == 8'h00) begin
                    mode_nxt = PM_HOLD;
                end else if (return_op && hold_resume_r) begin
                    mode_nxt = PM_HOLD;
                end
            end
            PM_HOLD: begin
                if (|hold_cand || take_any) begin
                    mode_nxt = PM_RUN;
                end
            end
            PM_STOP: begin
                if (stop_wake) begin
                    mode_nxt = PM_WARMUP;
                end
            end
            PM_WARMUP: begin
                if (warm_cnt_r == 32'(WARMUP_COUNT - 1)) begin
                    mode_nxt = PM_RUN;
                end
            end
            default: mode_nxt = PM_RUN;
        endcase
    end

    assign stop_wake = !ext_sync || |(port_fall & stop_wake_enable);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_r <= PM_RUN;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // Hold re-entry only when the interrupt alone ended hold
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hold_resume_r <= 1'b0;
        end else if (mode_r == PM_HOLD && take_any && !(|hold_cand)) begin
            hold_resume_r <= 1'b1;
        end else if (return_op || mode_r == PM_HOLD) begin
            hold_resume_r <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            warm_cnt_r <= 32'h0;
        end else if (mode_r == PM_WARMUP) begin
            warm_cnt_r <= warm_cnt_r + 32'h1;
        end else begin
            warm_cnt_r <= 32'h0;
        end
    end

    // Registered outputs
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_req     <= 1'b0;
            irq_vector  <= PC_RESET;
            in_isr      <= 1'b0;
            cpu_run     <= 1'b1;
            osc_run     <= 1'b1;
            power_mode  <= PM_RUN;
        end else begin
            irq_req <= take_any;
            if (take_any) begin
                irq_vector <= VEC_BASE +
                              VEC_STEP * PC_W'(take_idx);
                in_isr <= 1'b1;
            end else if (return_op) begin
                in_isr <= 1'b0;
            end
            cpu_run    <= (mode_nxt == PM_RUN);
            osc_run    <= (mode_nxt != PM_STOP);
            power_mode <= mode_nxt;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            serial_in_busy <= 1'b0;
        end else if (serial_rx_done) begin
            serial_in_busy <= 1'b0;
        end else if (serial_rx_start) begin
            serial_in_busy <= 1'b1;
        end
    end

    assign hold_cause_low_nibble  = hold_release_cause[3:0];
    assign hold_cause_high_nibble = hold_release_cause[7:4];

    chk_vector_in_range: assert property (
        @(posedge clock) disable iff (rst)
        irq_req |-> (irq_vector >= VEC_BASE && irq_vector <= VEC_LAST))
        else $error("vector outside range");
    chk_single_clear: assert property (
        @(posedge clock) disable iff (rst)
        take_any && !event_clear_op && ev_set == '0 |=>
        event_pending == ($past(event_pending) & ~$past(take_onehot)))
        else $error("acceptance cleared other pending bits");
    chk_block_after_take: assert property (
        @(posedge clock) disable iff (rst)
        take_any |=> !take_any)
        else $error("second interrupt taken back to back");
    chk_disable_blocks: assert property (
        @(posedge clock) disable iff (rst)
        global_irq_disable_op && !take_any |=> !take_any)
        else $error("interrupt taken after disable");
    chk_hold_refused: assert property (
        @(posedge clock) disable iff (rst)
        mode_r == PM_RUN && hold_op && !stop_op &&
        hold_release_cause != 8'h00 && !(return_op && hold_resume_r)
        |=> mode_r == PM_RUN)
        else $error("hold entered with cause set");
    chk_stop_wake: assert property (
        @(posedge clock) disable iff (rst)
        mode_r == PM_STOP && !ext_sync |=> mode_r == PM_WARMUP)
        else $error("low pin did not end stop");
    chk_warm_exit: assert property (
        @(posedge clock) disable iff (rst)
        mode_r == PM_WARMUP && warm_cnt_r != 32'(WARMUP_COUNT - 1)
        |=> mode_r == PM_WARMUP)
        else $error("warm-up cut short");
    chk_priority: assert property (
        @(posedge clock) disable iff (rst)
        take_any |-> irq_cand[take_idx] &&
        take_onehot == (8'h01 << take_idx) &&
        (irq_cand & ((8'h01 << take_idx) - 8'h01)) == 8'h00)
        else $error("not lowest pending source");
    chk_rx_busy: assert property (
        @(posedge clock) disable iff (rst)
        serial_rx_done |=> !serial_in_busy && event_pending[SRC_RX])
        else $error("receive done not reflected");
endmodule : irq_hold_stop_wake_control

// ---- tb/cpu_core_model.sv ----
`timescale 1ns/100ps
// Behavioural CPU core that accepts interrupts and returns from them
module cpu_core_model #(
    parameter int ISR_LEN = 4
) (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic stall,
    input  wire logic irq_req,
    output logic      irq_ack,
    output logic      return_op
);
    int count_r;

    // A stalled core answers late but never wrongly
    assign irq_ack = !stall;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_r   <= 0;
            return_op <= 1'b0;
        end else begin
            return_op <= (count_r == 1);  // Routine ends in a return
            if (irq_req) begin
                count_r <= ISR_LEN;
            end else if (count_r > 0) begin
                count_r <= count_r - 1;
            end
        end
    end
endmodule : cpu_core_model

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
// Self-checking bench for the interrupt and wake controller
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench;
    import irq_wake_pkg::*;
    localparam logic [14:0] W_IE = 15'h0001, W_HE = 15'h0002;
    localparam logic [14:0] W_PE = 15'h0004, W_SE = 15'h0008;
    localparam logic [14:0] OP_EN = 15'h0010, OP_DIS = 15'h0020;
    localparam logic [14:0] OP_CLR = 15'h0040, OP_HOLD = 15'h0080;
    localparam logic [14:0] OP_STOP = 15'h0100, EV_DIV = 15'h0200;
    localparam logic [14:0] EV_T0 = 15'h0400, EV_T1 = 15'h0800;
    localparam logic [14:0] EV_RXS = 15'h1000, EV_RXD = 15'h2000;
    localparam logic [14:0] EV_TXD = 15'h4000;
    localparam logic [14:0] HSRC [5] = '{EV_DIV, EV_T0, EV_T1, EV_RXD,
                                         EV_TXD};
    localparam logic [7:0]  HEN [5]  = '{8'h01, 8'h02, 8'h80, 8'h20, 8'h40};
    localparam logic [7:0]  HCS [5]  = '{8'h01, 8'h02, 8'h20, 8'h40, 8'h80};

    logic                clock, rst, ext_irq_n, stall;
    logic [3:0]          wake_port;
    logic [14:0]         st;
    logic [7:0]          wr_data;
    logic                ie_write, he_write, pe_write, se_write;
    logic                en_op, dis_op, clr_op, hold_op, stop_op, return_op;
    logic                div_ev, t0_ev, t1_ev, rxs, rxd, txd, irq_ack;
    logic                irq_req, serial_in_busy, cpu_run, osc_run, in_isr;
    logic [PC_W-1:0]     irq_vector, vec;
    logic [7:0]          event_pending;
    logic [3:0]          cause_lo, cause_hi;
    logic [1:0]          power_mode;
    int                  errors, n_compared, reqs, cycles;

    assign {txd, rxd, rxs, t1_ev, t0_ev, div_ev, stop_op, hold_op, clr_op,
            dis_op, en_op, se_write, pe_write, he_write, ie_write} = st;

    irq_hold_stop_wake_control #(.WARMUP_COUNT(8))
        irq_hold_stop_wake_control_i (
        .clock(clock), .rst(rst), .ext_irq_n(ext_irq_n), .wake_port(wake_port),
        .div_overflow(div_ev), .tmr0_underflow(t0_ev), .tmr1_underflow(t1_ev),
        .serial_rx_done(rxd), .serial_tx_done(txd), .serial_rx_start(rxs),
        .ie_write(ie_write), .he_write(he_write), .pe_write(pe_write),
        .se_write(se_write), .wr_data(wr_data), .global_irq_enable_op(en_op),
        .global_irq_disable_op(dis_op), .event_clear_op(clr_op),
        .event_clear_mask(wr_data), .hold_op(hold_op), .stop_op(stop_op),
        .return_op(return_op), .irq_ack(irq_ack), .irq_req(irq_req),
        .irq_vector(irq_vector), .event_pending(event_pending),
        .hold_cause_low_nibble(cause_lo), .hold_cause_high_nibble(cause_hi),
        .serial_in_busy(serial_in_busy), .cpu_run(cpu_run), .osc_run(osc_run),
        .power_mode(power_mode), .in_isr(in_isr));

    cpu_core_model #(.ISR_LEN(4)) cpu_core_model_i (
        .clock(clock), .rst(rst), .stall(stall), .irq_req(irq_req),
        .irq_ack(irq_ack), .return_op(return_op));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic summarize();
        if (errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            summarize();
        end
    end

    task automatic pulse(input logic [14:0] m, input logic [7:0] d);
        @(posedge clock);
        st      <= m;
        wr_data <= d;
        @(posedge clock);
        st      <= '0;
    endtask : pulse

    // Counts taken interrupts and keeps the first vector seen
    task automatic watch(input int n);
        reqs = 0;
        repeat (n) begin
            @(posedge clock);
            #1;
            if (irq_req === 1'b1) begin
                if (reqs == 0) vec = irq_vector;
                reqs++;
            end
        end
    endtask : watch

    task automatic clean();
        pulse(W_IE | W_HE | W_PE | W_SE, 8'h00);
        pulse(OP_CLR, 8'hFF);
    endtask : clean

    task automatic test_priority();
        clean();
        pulse(W_IE, 8'hFF);
        pulse(EV_DIV | EV_T0, 8'h00);
        watch(8);
        `CHK(reqs, 1)
        `CHK(vec, 11'h004)
        `CHK(event_pending[1:0], 2'b10)
        pulse(OP_EN, 8'h00);
        watch(8);
        `CHK(reqs, 1)
        `CHK(vec, 11'h008)
    endtask : test_priority

    task automatic test_disable();
        clean();
        pulse(W_IE, 8'h80);
        pulse(OP_DIS, 8'h00);
        pulse(EV_T1, 8'h00);
        watch(8);
        `CHK(reqs, 0)
        `CHK(event_pending[7], 1'b1)
        @(posedge clock);
        stall <= 1'b1;
        pulse(OP_EN, 8'h00);
        watch(6);
        `CHK(reqs, 0)
        @(posedge clock);
        stall <= 1'b0;
        watch(8);
        `CHK(reqs, 1)
        `CHK(vec, 11'h020)
        `CHK(event_pending[7], 1'b0)
    endtask : test_disable

    task automatic test_serial();
        clean();
        pulse(EV_RXS, 8'h00);
        watch(2);
        `CHK(serial_in_busy, 1'b1)
        pulse(EV_RXD, 8'h00);
        watch(2);
        `CHK(serial_in_busy, 1'b0)
        `CHK(event_pending[5], 1'b1)
        pulse(EV_TXD, 8'h00);
        watch(2);
        `CHK(event_pending[6], 1'b1)
    endtask : test_serial

    task automatic test_pins();
        clean();
        pulse(W_PE, 8'h01);
        pulse(W_IE, 8'h14);
        @(posedge clock);
        wake_port <= 4'hE;
        watch(8);
        `CHK(reqs, 1)
        `CHK(vec, 11'h00C)
        `CHK(in_isr, 1'b1)
        @(posedge clock);
        wake_port <= 4'hF;
        @(posedge clock);
        ext_irq_n <= 1'b0;
        watch(8);
        `CHK(reqs, 0)
        `CHK(event_pending[4], 1'b1)
        `CHK(event_pending[2], 1'b1)
        pulse(OP_EN, 8'h00);
        watch(8);
        `CHK(reqs, 1)
        `CHK(vec, 11'h00C)
        @(posedge clock);
        ext_irq_n <= 1'b1;
    endtask : test_pins

    task automatic test_hold();
        for (int i = 0; i < 5; i++) begin
            clean();
            pulse(W_HE, HEN[i]); // Release masks set first
            pulse(OP_HOLD, 8'h00);
            watch(2);
            `CHK(power_mode, PM_HOLD)
            `CHK(cpu_run, 1'b0)
            pulse(HSRC[i], 8'h00);
            watch(4);
            `CHK(power_mode, PM_RUN)
            `CHK({cause_hi, cause_lo}, HCS[i])
        end
        pulse(OP_HOLD, 8'h00);
        watch(2);
        `CHK(power_mode, PM_RUN)
        pulse(OP_CLR, 8'hFF);
        pulse(W_HE, 8'h00);
        watch(2);
        `CHK({cause_hi, cause_lo}, 8'h00)
    endtask : test_hold

    task automatic test_stop();
        int n;
        clean();
        pulse(W_SE, 8'h01);
        for (int i = 0; i < 2; i++) begin
            pulse(OP_STOP, 8'h00);
            watch(2);
            `CHK(power_mode, PM_STOP)
            `CHK(osc_run, 1'b0)
            @(posedge clock);
            if (i == 0) wake_port <= 4'hE;
            else ext_irq_n <= 1'b0;
            n = 0;
            while (power_mode === PM_STOP && n < 10) begin
                @(posedge clock);
                #1;
                n++;
            end
            `CHK(power_mode, PM_WARMUP)
            watch(12);
            `CHK(power_mode, PM_RUN)
            `CHK(cpu_run, 1'b1)
            `CHK(osc_run, 1'b1)
            @(posedge clock);
            wake_port <= 4'hF;
            ext_irq_n <= 1'b1;
            watch(4);
        end
    endtask : test_stop

    task automatic test_hold_isr();
        clean();
        pulse(W_IE, 8'h01);
        pulse(OP_HOLD, 8'h00);
        watch(2);
        `CHK(power_mode, PM_HOLD)
        pulse(EV_DIV, 8'h00);
        watch(6);
        `CHK(reqs, 1)
        watch(10);
        `CHK(power_mode, PM_HOLD)
        `CHK(in_isr, 1'b0)
    endtask : test_hold_isr

    initial begin
        rst       = 1'b1;
        ext_irq_n = 1'b1;
        wake_port = 4'hF;
        st        = '0;
        wr_data   = 8'h00;
        stall     = 1'b0;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        watch(3);
        `CHK(irq_vector, PC_RESET)
        `CHK(event_pending, 8'h00)
        `CHK({cause_hi, cause_lo}, 8'h00)
        `CHK(power_mode, PM_RUN)
        test_priority();
        test_disable();
        test_serial();
        test_pins();
        test_hold();
        test_stop();
        test_hold_isr();
        summarize();
    end
endmodule : testbench
